// [src/sram_array.sv]
// Storage array with registered read data and write-first bypass
`timescale 1ns/1ns
`default_nettype none
module sram_array #(
    parameter int AW = 15,
    parameter int DW = 9
) (
    input  wire logic          clk_i,
    input  wire logic          reset_n_i,
    input  wire logic          ce_i,
    input  wire logic          rd_en_i,
    input  wire logic [AW-1:0] rd_addr_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [DW-1:0] wr_data_i,
    output logic      [DW-1:0] rd_data_o
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_i) begin
        if (ce_i && wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // A read hitting the word being committed returns the new word
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= '0;
        end else if (ce_i && rd_en_i) begin
            if (wr_en_i && (wr_addr_i == rd_addr_i)) begin
                rd_data_o <= wr_data_i;
            end else begin
                rd_data_o <= mem[rd_addr_i];
            end
        end
    end

endmodule
`default_nettype wire

// [src/sync_sram_32k_by_9.sv]
// Synchronous 32K x 9 static memory with registered inputs
`timescale 1ns/1ns
`default_nettype none
module sync_sram_32k_by_9 #(
    parameter int ADDR_W = sync_sram_pkg::ADDR_W,
    parameter int DATA_W = sync_sram_pkg::DATA_W
) (
    input  wire logic              sys_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              ce_i,
    input  wire logic [ADDR_W-1:0] addr_lines_i,
    input  wire logic              select_active_high_i,
    input  wire logic              select_active_low_n_i,
    input  wire logic              wr_strobe_n_i,
    input  wire logic              out_en_n_i,
    input  wire logic [DATA_W-1:0] data_io_bus_i,
    output logic      [DATA_W-1:0] data_io_bus_o,
    output logic                   data_io_bus_oe_o,
    output logic                   selected_o,
    output logic                   cycle_read_o,
    output logic                   cycle_write_o,
    output logic                   write_done_o
);

    // Both selects must agree; any other pairing deselects
    function automatic logic sel_decode(input logic hi, input logic lo_n);
        sel_decode = hi & ~lo_n;
    endfunction

    logic [ADDR_W-1:0]          addr_reg;
    logic                       sel_reg;
    logic [DATA_W-1:0]          wr_data_reg;
    sync_sram_pkg::cycle_kind_t kind_reg;
    sync_sram_pkg::cycle_kind_t kind_next;
    logic                       pos_tog_reg;
    logic                       neg_tog_reg;
    logic                       kind_known;
    logic                       write_go;
    logic                       write_block;
    logic                       rd_en;
    logic [DATA_W-1:0]          rd_data;
    logic                       write_done_reg;

    // Rising edge: address and selects, straight from the pins
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_reg <= sync_sram_pkg::ADDR_RST;
            sel_reg  <= sync_sram_pkg::SEL_RST;
        end else if (ce_i) begin
            addr_reg <= addr_lines_i;
            sel_reg  <= sel_decode(select_active_high_i,
                                   select_active_low_n_i);
        end
    end

    // Marks the start of each cycle; the falling edge copies it back
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pos_tog_reg <= sync_sram_pkg::TOG_RST;
        end else if (ce_i) begin
            pos_tog_reg <= ~pos_tog_reg;
        end
    end

    // Cycle kind is settled only after the falling edge of this cycle
    always_comb begin
        if (!sel_reg) begin
            kind_next = sync_sram_pkg::CYC_DESELECT;
        end else if (wr_strobe_n_i) begin
            kind_next = sync_sram_pkg::CYC_READ;
        end else begin
            kind_next = sync_sram_pkg::CYC_WRITE;
        end
    end

    // Falling edge: write strobe and write data off the shared pins
    always_ff @(negedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            kind_reg    <= sync_sram_pkg::KIND_RST;
            wr_data_reg <= sync_sram_pkg::DATA_RST;
            neg_tog_reg <= sync_sram_pkg::TOG_RST;
        end else if (ce_i) begin
            kind_reg    <= kind_next;
            wr_data_reg <= data_io_bus_i;
            neg_tog_reg <= pos_tog_reg;
        end
    end

    assign kind_known = (neg_tog_reg == pos_tog_reg);

    // Self-timed commit at the rising edge that closes the write cycle;
    // the toggle pair keeps a frozen kind from writing twice
    always_comb begin
        case (kind_reg)
            sync_sram_pkg::CYC_WRITE: write_go = kind_known;
            sync_sram_pkg::CYC_READ:  write_go = 1'b0;
            default:                  write_go = 1'b0;
        endcase
    end

    // Array read is fired by the same edge that takes the address
    assign rd_en = sel_decode(select_active_high_i,
                              select_active_low_n_i);

    sram_array #(
        .AW (ADDR_W),
        .DW (DATA_W)
    ) u_array (
        .clk_i     (sys_clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .rd_en_i   (rd_en),
        .rd_addr_i (addr_lines_i),
        .wr_en_i   (write_go),
        .wr_addr_i (addr_reg),
        .wr_data_i (wr_data_reg),
        .rd_data_o (rd_data)
    );

    // No output stage: array read register feeds the pins directly
    assign data_io_bus_o = rd_data;

    // Once the cycle is known to be a write, never fight the controller
    assign write_block = kind_known &&
                         (kind_reg == sync_sram_pkg::CYC_WRITE);

    // Enable pin goes straight to the driver so it acts without a clock
    assign data_io_bus_oe_o = sel_reg & ~out_en_n_i
                              & ~write_block;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            write_done_reg <= sync_sram_pkg::FLAG_RST;
        end else if (ce_i) begin
            write_done_reg <= write_go;
        end
    end

    assign write_done_o  = write_done_reg;
    assign selected_o    = sel_reg;
    assign cycle_read_o  = kind_known &&
                           (kind_reg == sync_sram_pkg::CYC_READ);
    assign cycle_write_o = write_block;

endmodule
`default_nettype wire

// [src/sync_sram_pkg.sv]
// Constants and types shared by the synchronous 32K x 9 static memory
// What this block does
// - Hold 32768 words of nine bits each
// - Register address and selects on rising edge
// - Register write strobe, data on falling edge
// - Output enable acts directly, never registered
// - Selected only when low-select low, high-select high
// - Read drives addressed word while enable low
// - Write stores captured word at registered address
// - Write pulse is generated internally
// - Nine shared pins carry read and write data
// - Pins released unless output enable permits
package sync_sram_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 9;
    localparam int DEPTH  = 32768;

    localparam logic [ADDR_W-1:0] ADDR_RST  = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST  = 9'h000;
    localparam logic              SEL_RST   = 1'b0;
    localparam logic              TOG_RST   = 1'b0;
    localparam logic              FLAG_RST  = 1'b0;

    // Kind of the current cycle, known once the falling edge has passed
    typedef enum logic [1:0] {
        CYC_DESELECT,
        CYC_READ,
        CYC_WRITE
    } cycle_kind_t;

    localparam cycle_kind_t KIND_RST = CYC_DESELECT;

endpackage

// [tb/sram_host_model.sv]
// Cache controller model: write strobe, write data and output enable
`timescale 1ns/1ns
`default_nettype none
module sram_host_model (
    input  wire logic       clk_i,
    input  wire logic       we_i,
    input  wire logic       oe_n_i,
    input  wire logic [8:0] wdata_i,
    output logic            strobe_n_o,
    output logic            out_en_n_o,
    output logic      [8:0] dq_o
);
    logic       we_reg = 1'b0;
    logic [8:0] wd_reg = 9'h000;
    logic [8:0] dq_reg = 9'h000;
    // Strobe and data trail the address by one cycle for the falling edge
    assign strobe_n_o = ~we_reg;
    // Held high over both halves of a write so the bus is never fought
    assign out_en_n_o = oe_n_i | we_i | we_reg;
    assign dq_o = we_reg ? wd_reg : dq_reg;
    always_ff @(posedge clk_i) begin
        we_reg <= we_i;
        wd_reg <= wdata_i;
        // A released bus shows the inverse, never a stale word
        dq_reg <= ~dq_o;
    end
endmodule
`default_nettype wire

// [tb/sync_sram_sva.sv]
// Port assertions for the synchronous memory
`timescale 1ns/1ns
`default_nettype none
module sync_sram_sva (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic select_active_high_i,
    input wire logic select_active_low_n_i,
    input wire logic out_en_n_i,
    input wire logic data_io_bus_oe_o,
    input wire logic selected_o,
    input wire logic cycle_read_o,
    input wire logic cycle_write_o,
    input wire logic write_done_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_sel_decode: assert property (ce_i |=> selected_o ==
        $past(select_active_high_i & ~select_active_low_n_i)) else $error("sel");
    a_desel_hiz: assert property (!selected_o |-> !data_io_bus_oe_o)
        else $error("desel oe");
    a_oe_follow: assert property (selected_o & !cycle_write_o & !out_en_n_i
        |-> data_io_bus_oe_o) else $error("oe follow");
    a_oe_off: assert property (out_en_n_i |-> !data_io_bus_oe_o)
        else $error("oe off");
    a_write_quiet: assert property (cycle_write_o |-> !data_io_bus_oe_o)
        else $error("oe in write");
    a_write_done: assert property (cycle_write_o & ce_i |=> write_done_o)
        else $error("no done");
    a_done_cause: assert property (write_done_o |-> $past(cycle_write_o))
        else $error("stray done");
    a_kind_sel: assert property (cycle_read_o | cycle_write_o |->
        selected_o & !(cycle_read_o & cycle_write_o)) else $error("kind");
endmodule
`default_nettype wire

// [tb/test_sync_sram_32k_by_9.sv]
// Random back-to-back reads and writes against the synchronous memory
`timescale 1ns/1ns
`default_nettype none
module test_sync_sram_32k_by_9;
    logic sys_clk_i = 0, reset_n_i = 0, hi = 0, lo_n = 1, we = 0, oe_n = 1;
    logic [14:0] addr = 15'h0000, p_a;
    logic [8:0] wdata = 9'h000, pin, dout, drv, p_d;
    logic strobe_n, oen, oe, sel, done, p_sel, p_we, pp_w;
    logic [31:0] r;
    logic [8:0] mem [int];
    int miscompares = 0, n_tests = 0, cyc = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    sram_host_model host_u (.clk_i(sys_clk_i), .we_i(we), .oe_n_i(oe_n),
        .wdata_i(wdata), .strobe_n_o(strobe_n), .out_en_n_o(oen), .dq_o(drv));
    assign pin = oe ? dout : drv;
    sync_sram_32k_by_9 dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .ce_i(1'b1), .addr_lines_i(addr), .select_active_high_i(hi),
        .select_active_low_n_i(lo_n), .wr_strobe_n_i(strobe_n),
        .out_en_n_i(oen), .data_io_bus_i(pin), .data_io_bus_o(dout),
        .data_io_bus_oe_o(oe), .selected_o(sel), .cycle_read_o(),
        .cycle_write_o(), .write_done_o(done));
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            results;
        end
    end
    initial begin
        void'($urandom(25));
        {p_sel, p_we, pp_w} = 3'h0;
        repeat (20) @(posedge sys_clk_i);
        reset_n_i <= 1;
        for (int i = 0; i < 1500; i++) begin
            @(posedge sys_clk_i);
            r = $urandom;
            hi <= r[0] | r[1];
            lo_n <= r[2] & r[3];
            we <= r[4];
            oe_n <= r[5] & r[6];
            addr <= (i % 64 == 0) ? 15'h7fff : {12'h000, r[18:16]};
            wdata <= r[27:19];
            #1;
            check({8'h00, sel}, {8'h00, p_sel});
            check({8'h00, done}, {8'h00, pp_w});
            check({8'h00, oe}, {8'h00, p_sel & ~p_we & ~oen});
            if (oe) check(pin, dout);
            if (p_sel & ~p_we & mem.exists(p_a)) check(dout, mem[p_a]);
            if (p_sel & p_we) mem[p_a] = p_d;
            pp_w = p_sel & p_we;
            p_sel = (r[0] | r[1]) & ~(r[2] & r[3]);
            p_we = r[4];
            p_a = (i % 64 == 0) ? 15'h7fff : {12'h000, r[18:16]};
            p_d = r[27:19];
        end
        results;
    end
endmodule
bind sync_sram_32k_by_9 sync_sram_sva sva_u (.*);
`default_nettype wire
